// >>> rtl/stfs_deglitch.sv
`timescale 1ns/1ps
module stfs_deglitch #(
    parameter int CYCLES = 500
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Condition
    input wire logic raw,
    output logic filtered
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] count_reg;

    if (CYCLES < 1) begin : g_bad
        $error("stfs_deglitch: CYCLES must be at least 1");
    end

    // Any drop restarts the count, so short glitches never reach the output
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_reg <= '0;
            filtered <= 1'b0;
        end else if (!raw) begin
            count_reg <= '0;
            filtered <= 1'b0;
        end else if (count_reg == LAST) begin
            filtered <= 1'b1;
        end else begin
            count_reg <= count_reg + CW'(1);
        end
    end
endmodule

// >>> rtl/stfs_pkg.sv
package stfs_pkg;
    localparam int NUM_CH = 5;
    localparam int CLK_PERIOD_NS = 10;

    // Filter times in ns, autorestart period in ms
    localparam int OTS_FILTER_NS = 5000;
    localparam int SUPPLY_FILTER_NS = 3500;
    localparam int PUMP_FILTER_NS = 4000;
    localparam int AUTORESTART_MS = 64;
    localparam int OTS_FILTER_CYC = (OTS_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SUPPLY_FILTER_CYC = (SUPPLY_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PUMP_FILTER_CYC = (PUMP_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int AUTORESTART_CYC = AUTORESTART_MS * 1000000 / CLK_PERIOD_NS;

    // Register byte offsets
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CONFIG = 8'h00;
    localparam logic [7:0] REG_QUICK_STATUS = 8'h04;
    localparam logic [7:0] REG_CH_STATUS_BASE = 8'h08;
    localparam logic [7:0] REG_DEVICE_STATUS = 8'h1C;
    localparam logic [7:0] REG_OUTPUT_CTRL = 8'h20;
    localparam logic [7:0] REG_CH_CTRL_BASE = 8'h24;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h38;
    localparam logic [7:0] REG_IRQ_MASK = 8'h3C;
    localparam logic [7:0] REG_STRIDE = 8'h04;

    // Field positions
    localparam int CFG_WSEL_BIT = 0;
    localparam int QS_WARN_LSB = 0;
    localparam int QS_SD_LSB = 5;
    localparam int QS_PUMP_BIT = 10;
    localparam int QS_DSF_BIT = 11;
    localparam int CS_WARN_BIT = 0;
    localparam int CS_SD_BIT = 1;
    localparam int CS_DSF_BIT = 2;
    localparam int DS_LOW_BIT = 0;
    localparam int DS_HIGH_BIT = 1;
    localparam int DS_DSF_BIT = 2;
    localparam int CTRL_ON_BIT = 0;

    // Interrupt events
    localparam int NUM_EV = 5;
    localparam int EV_WARN = 0;
    localparam int EV_SHUTDOWN = 1;
    localparam int EV_LOW_SUPPLY = 2;
    localparam int EV_HIGH_SUPPLY = 3;
    localparam int EV_PUMP = 4;

    // Reset values
    localparam logic CFG_WSEL_RESET = 1'b0;
    localparam logic [4:0] IRQ_MASK_RESET = 5'h00;
    localparam logic [4:0] CMD_RESET = 5'h00;

    typedef struct packed {
        logic [4:0] warn_high;
        logic [4:0] warn_low;
        logic [4:0] shutdown;
        logic supply_low;
        logic supply_high;
        logic pump_ok;
    } stfs_sense_t;
endpackage

// >>> rtl/stfs_supervisor.sv
`timescale 1ns/1ps
module stfs_supervisor
    import stfs_pkg::*;
#(
    parameter int OTS_CYCLES = OTS_FILTER_CYC,
    parameter int SUPPLY_CYCLES = SUPPLY_FILTER_CYC,
    parameter int PUMP_CYCLES = PUMP_FILTER_CYC,
    parameter int AUTORESTART_CYCLES = AUTORESTART_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Analog comparators and mode
    input wire stfs_sense_t sense,
    input wire logic fail_mode,
    // Power stage
    output logic [NUM_CH-1:0] out_en,
    output logic [NUM_CH-1:0] inrush_overcurrent_window,
    // Interrupt
    output logic irq
);
    localparam int AW = $clog2(AUTORESTART_CYCLES + 1);
    localparam logic [AW-1:0] AR_LAST = AW'(AUTORESTART_CYCLES - 1);

    if (AUTORESTART_CYCLES < 2 || OTS_CYCLES < 1 || SUPPLY_CYCLES < 1 || PUMP_CYCLES < 1) begin : g_bad
        $error("stfs_supervisor: cycle counts out of range");
    end

    // One-hot channel decode of a register bank
    function automatic logic [NUM_CH-1:0] chan_hit(input logic [7:0] addr, input logic [7:0] base);
        logic [NUM_CH-1:0] hit;
        hit = '0;
        for (int k = 0; k < NUM_CH; k++) begin
            if (addr == base + 8'(k) * REG_STRIDE) begin
                hit[k] = 1'b1;
            end
        end
        return hit;
    endfunction

    logic wait_reg;
    logic [31:0] rdata_reg;
    logic wsel_reg;
    logic [NUM_CH-1:0] cmd_reg;
    logic [NUM_CH-1:0] warn_flag_reg;
    logic [NUM_CH-1:0] sd_flag_reg;
    logic [NUM_CH-1:0] ts_off_reg;
    logic uv_off_reg;
    logic low_flag_reg;
    logic high_flag_reg;
    logic pump_flag_reg;
    logic pump_settled_reg;
    logic fail_mode_reg;
    logic [AW-1:0] ar_count_reg;
    logic ar_tick_reg;
    logic [NUM_CH-1:0] out_en_reg;
    logic [NUM_CH-1:0] inrush_reg;
    logic [NUM_EV-1:0] irq_stat_reg;
    logic [NUM_EV-1:0] irq_mask_reg;
    logic irq_reg;
    logic [NUM_CH-1:0] warn_sd_prev_reg;
    logic low_prev_reg;
    logic high_prev_reg;
    logic pump_prev_reg;

    logic [NUM_CH-1:0] ts_filt;
    logic uv_filt;
    logic pump_fail_filt;
    logic [NUM_CH-1:0] warn_raw;
    logic acc_rd;
    logic acc_wr;
    logic wr_lo;
    logic [NUM_CH-1:0] stat_hit;
    logic [NUM_CH-1:0] ctrl_hit;
    logic [NUM_CH-1:0] on_write;
    logic [NUM_CH-1:0] cmd_next;
    logic [NUM_CH-1:0] stat_read;
    logic dev_read;
    logic quick_read;
    logic device_fault_summary_flag;
    logic pump_gate;
    logic mode_change;
    logic [NUM_CH-1:0] out_en_next;
    logic [NUM_EV-1:0] events;
    logic [31:0] rdata_next;

    // Deglitch filters
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ots
        stfs_deglitch #(.CYCLES(OTS_CYCLES)) u_ots (
            .clk(clk),
            .arst_n(arst_n),
            .raw(sense.shutdown[i]),
            .filtered(ts_filt[i])
        );
    end

    stfs_deglitch #(.CYCLES(SUPPLY_CYCLES)) u_uv (
        .clk(clk),
        .arst_n(arst_n),
        .raw(sense.supply_low),
        .filtered(uv_filt)
    );

    // Power-up settling is not a pump fault
    stfs_deglitch #(.CYCLES(PUMP_CYCLES)) u_pump (
        .clk(clk),
        .arst_n(arst_n),
        .raw(pump_settled_reg && !sense.pump_ok),
        .filtered(pump_fail_filt)
    );

    assign warn_raw = wsel_reg ? sense.warn_low : sense.warn_high;

    // Bus decode; accesses complete on the edge that sees waitrequest low
    assign acc_rd = avs_read && !wait_reg;
    assign acc_wr = avs_write && !wait_reg;
    assign wr_lo = acc_wr && avs_byteenable[0];
    assign stat_hit = chan_hit(avs_address, REG_CH_STATUS_BASE);
    assign ctrl_hit = chan_hit(avs_address, REG_CH_CTRL_BASE);
    assign stat_read = acc_rd ? stat_hit : '0;
    assign dev_read = acc_rd && avs_address == REG_DEVICE_STATUS;
    assign quick_read = acc_rd && avs_address == REG_QUICK_STATUS;
    assign device_fault_summary_flag = low_flag_reg || high_flag_reg || pump_flag_reg;
    assign mode_change = fail_mode != fail_mode_reg;

    always_comb begin
        on_write = '0;
        cmd_next = cmd_reg;
        if (wr_lo && avs_address == REG_OUTPUT_CTRL) begin
            cmd_next = avs_writedata[NUM_CH-1:0];
            on_write = avs_writedata[NUM_CH-1:0];
        end else begin
            for (int k = 0; k < NUM_CH; k++) begin
                if (wr_lo && ctrl_hit[k]) begin
                    cmd_next[k] = avs_writedata[CTRL_ON_BIT];
                    on_write[k] = avs_writedata[CTRL_ON_BIT];
                end
            end
        end
    end

    always_comb begin
        rdata_next = '0;
        if (avs_address == REG_CONFIG) begin
            rdata_next[CFG_WSEL_BIT] = wsel_reg;
        end else if (avs_address == REG_QUICK_STATUS) begin
            rdata_next[QS_WARN_LSB +: NUM_CH] = warn_flag_reg;
            rdata_next[QS_SD_LSB +: NUM_CH] = sd_flag_reg;
            rdata_next[QS_PUMP_BIT] = pump_flag_reg;
            rdata_next[QS_DSF_BIT] = device_fault_summary_flag;
        end else if (|stat_hit) begin
            for (int k = 0; k < NUM_CH; k++) begin
                if (stat_hit[k]) begin
                    rdata_next[CS_WARN_BIT] = warn_flag_reg[k];
                    rdata_next[CS_SD_BIT] = sd_flag_reg[k];
                end
            end
            rdata_next[CS_DSF_BIT] = device_fault_summary_flag;
        end else if (avs_address == REG_DEVICE_STATUS) begin
            rdata_next[DS_LOW_BIT] = low_flag_reg;
            rdata_next[DS_HIGH_BIT] = high_flag_reg;
            rdata_next[DS_DSF_BIT] = device_fault_summary_flag;
        end else if (avs_address == REG_OUTPUT_CTRL) begin
            rdata_next[NUM_CH-1:0] = cmd_reg;
        end else if (|ctrl_hit) begin
            rdata_next[CTRL_ON_BIT] = |(cmd_reg & ctrl_hit);
        end else if (avs_address == REG_IRQ_STATUS) begin
            rdata_next[NUM_EV-1:0] = irq_stat_reg;
        end else if (avs_address == REG_IRQ_MASK) begin
            rdata_next[NUM_EV-1:0] = irq_mask_reg;
        end
    end

    // One wait cycle per access, then one cycle with waitrequest low
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_reg <= 1'b1;
            rdata_reg <= '0;
        end else if ((avs_read || avs_write) && wait_reg) begin
            wait_reg <= 1'b0;
            rdata_reg <= rdata_next;
        end else begin
            wait_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wsel_reg <= CFG_WSEL_RESET;
            irq_mask_reg <= IRQ_MASK_RESET;
            cmd_reg <= CMD_RESET;
        end else begin
            cmd_reg <= cmd_next;
            if (wr_lo && avs_address == REG_CONFIG) begin
                wsel_reg <= avs_writedata[CFG_WSEL_BIT];
            end
            if (wr_lo && avs_address == REG_IRQ_MASK) begin
                irq_mask_reg <= avs_writedata[NUM_EV-1:0];
            end
        end
    end

    // Per-channel thermal flags and shutdown latch; a new set wins over a read clear
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                warn_flag_reg[i] <= 1'b0;
            end else if (warn_raw[i]) begin
                warn_flag_reg[i] <= 1'b1;
            end else if (stat_read[i]) begin
                warn_flag_reg[i] <= 1'b0;
            end
        end

        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                sd_flag_reg[i] <= 1'b0;
            end else if (ts_filt[i]) begin
                sd_flag_reg[i] <= 1'b1;
            end else if (stat_read[i]) begin
                sd_flag_reg[i] <= 1'b0;
            end
        end

        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                ts_off_reg[i] <= 1'b0;
            end else if (ts_filt[i]) begin
                ts_off_reg[i] <= 1'b1;
            end else if (fail_mode_reg && mode_change) begin
                ts_off_reg[i] <= 1'b0;
            end else if (!fail_mode_reg && on_write[i]) begin
                ts_off_reg[i] <= 1'b0;
            end
        end
    end

    // Supply latches
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            uv_off_reg <= 1'b0;
        end else if (uv_filt) begin
            uv_off_reg <= 1'b1;
        end else if (!fail_mode_reg && |on_write) begin
            uv_off_reg <= 1'b0;
        end else if (fail_mode_reg && ar_tick_reg) begin
            uv_off_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            low_flag_reg <= 1'b0;
        end else if (uv_filt) begin
            low_flag_reg <= 1'b1;
        end else if (dev_read) begin
            low_flag_reg <= 1'b0;
        end
    end

    // Overvoltage is reported without a filter
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            high_flag_reg <= 1'b0;
        end else if (sense.supply_high) begin
            high_flag_reg <= 1'b1;
        end else if (dev_read) begin
            high_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pump_flag_reg <= 1'b0;
        end else if (pump_fail_filt) begin
            pump_flag_reg <= 1'b1;
        end else if (quick_read) begin
            pump_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pump_settled_reg <= 1'b0;
        end else if (sense.pump_ok) begin
            pump_settled_reg <= 1'b1;
        end
    end

    // Autorestart period runs only in Fail mode, so the first retry is a full period after entry
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fail_mode_reg <= 1'b0;
            ar_count_reg <= '0;
            ar_tick_reg <= 1'b0;
        end else begin
            fail_mode_reg <= fail_mode;
            ar_tick_reg <= 1'b0;
            if (!fail_mode_reg) begin
                ar_count_reg <= '0;
            end else if (ar_count_reg == AR_LAST) begin
                ar_count_reg <= '0;
                ar_tick_reg <= 1'b1;
            end else begin
                ar_count_reg <= ar_count_reg + AW'(1);
            end
        end
    end

    // Pump gate: off before settling and during a filtered fault; the raw comparator is also
    // gated in, so a pump that flickers inside the filter turns outputs off for each low cycle
    assign pump_gate = pump_settled_reg && sense.pump_ok && !pump_fail_filt;
    assign out_en_next = cmd_reg & ~ts_off_reg & ~ts_filt & {NUM_CH{!uv_off_reg && !uv_filt && pump_gate}};

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out_en_reg <= '0;
            inrush_reg <= '0;
        end else begin
            out_en_reg <= out_en_next;
            inrush_reg <= out_en_next & ~out_en_reg;
        end
    end

    // Interrupt events on the rising edge of each latched flag, except shutdown: ts_filt while its sd_flag_reg is still clear
    assign events[EV_WARN] = |(warn_flag_reg & ~warn_sd_prev_reg);
    assign events[EV_SHUTDOWN] = |(ts_filt & ~sd_flag_reg);
    assign events[EV_LOW_SUPPLY] = low_flag_reg && !low_prev_reg;
    assign events[EV_HIGH_SUPPLY] = high_flag_reg && !high_prev_reg;
    assign events[EV_PUMP] = pump_flag_reg && !pump_prev_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            warn_sd_prev_reg <= '0;
            low_prev_reg <= 1'b0;
            high_prev_reg <= 1'b0;
            pump_prev_reg <= 1'b0;
            irq_stat_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            warn_sd_prev_reg <= warn_flag_reg;
            low_prev_reg <= low_flag_reg;
            high_prev_reg <= high_flag_reg;
            pump_prev_reg <= pump_flag_reg;
            if (wr_lo && avs_address == REG_IRQ_STATUS) begin
                irq_stat_reg <= (irq_stat_reg & ~avs_writedata[NUM_EV-1:0]) | events;
            end else begin
                irq_stat_reg <= irq_stat_reg | events;
            end
            irq_reg <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    assign avs_waitrequest = wait_reg;
    assign avs_readdata = rdata_reg;
    assign out_en = out_en_reg;
    assign inrush_overcurrent_window = inrush_reg;
    assign irq = irq_reg;
endmodule

// >>> test/stfs_mcu_model.sv
`timescale 1ns/1ps
module stfs_mcu_model
    import stfs_pkg::*;
(
    // Clock
    input wire logic clk,
    // Avalon-MM master
    output logic [ADDR_W-1:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    initial begin
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
    end

    // Reads release latched flags, writes of the on bit restart outside Fail mode
    task automatic access(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                          output logic [31:0] rdata);
        @(posedge clk);
        avs_address <= addr;
        avs_writedata <= wdata;
        avs_byteenable <= 4'hF;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // Released data is scrambled so stale values are never reused
        avs_writedata <= ~wdata;
        avs_byteenable <= 4'h0;
    endtask
endmodule

// >>> test/stfs_supervisor_sva.sv
`timescale 1ns/1ps
module stfs_supervisor_sva
    import stfs_pkg::*;
#(
    parameter int OTS_CYCLES = OTS_FILTER_CYC,
    parameter int SUPPLY_CYCLES = SUPPLY_FILTER_CYC,
    parameter int PUMP_CYCLES = PUMP_FILTER_CYC,
    parameter int AUTORESTART_CYCLES = AUTORESTART_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Bus
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // Sense and power stage
    input wire stfs_sense_t sense,
    input wire logic [NUM_CH-1:0] out_en,
    input wire logic [NUM_CH-1:0] inrush_overcurrent_window
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    logic pump_seen_reg;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pump_seen_reg <= 1'b0;
        end else if (sense.pump_ok) begin
            pump_seen_reg <= 1'b1;
        end
    end

    AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest did not drop after one cycle");
    AST_WAIT_BACK: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    // Repetition counts assume the reduced filter lengths of the bench
    AST_UV_OFF: assert property (sense.supply_low [*8] |-> out_en == 5'h00)
        else $error("outputs on during filtered undervoltage");
    AST_PUMP_OFF: assert property (!sense.pump_ok [*3] |-> out_en == 5'h00)
        else $error("outputs on during pump fault");
    AST_POWERUP_OFF: assert property (!pump_seen_reg |-> out_en == 5'h00)
        else $error("outputs on before pump settled");
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        AST_SD_OFF: assert property (sense.shutdown[i] [*8] |-> !out_en[i])
            else $error("channel on during filtered shutdown");
        AST_INRUSH_START: assert property ($rose(out_en[i]) |-> inrush_overcurrent_window[i])
            else $error("inrush window missing at turn-on");
        AST_INRUSH_ONE: assert property (inrush_overcurrent_window[i] |=> !inrush_overcurrent_window[i])
            else $error("inrush pulse longer than one cycle");
        AST_ON_PUMP: assert property ($rose(out_en[i]) |-> $past(sense.pump_ok))
            else $error("channel turned on without valid pump");
    end
endmodule

// >>> test/stfs_supervisor_tb.sv
`timescale 1ns/1ps
module stfs_supervisor_tb
    import stfs_pkg::*;
;
    localparam int OTS_N = 5;
    localparam int SUP_N = 4;
    localparam int AUTO_N = 50;
    logic clk, arst_n, avs_read, avs_write, avs_waitrequest, fail_mode, irq;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rdat;
    logic [3:0] avs_byteenable;
    logic [4:0] out_en, inrush;
    stfs_sense_t sense;
    int err_total, num_checks, cyc_cnt;

    stfs_supervisor #(.OTS_CYCLES(OTS_N), .SUPPLY_CYCLES(SUP_N), .PUMP_CYCLES(4), .AUTORESTART_CYCLES(AUTO_N)) uut (
        .clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sense(sense), .fail_mode(fail_mode), .out_en(out_en),
        .inrush_overcurrent_window(inrush), .irq(irq));
    stfs_mcu_model mcu (.clk(clk), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            err_total++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        mcu.access(1'b1, a, d, unused);
    endtask
    task automatic rd(input logic [7:0] a);
        mcu.access(1'b0, a, 32'h0, rdat);
    endtask
    function automatic logic [7:0] cs(input int i);
        return REG_CH_STATUS_BASE + REG_STRIDE * 8'(i);
    endfunction
    // Bounded wait for the outputs to reach a pattern, then compare
    task automatic wait_out(input logic [4:0] exp, input int lim);
        int n;
        n = 0;
        while (out_en !== exp && n < lim) begin
            @(posedge clk);
            n++;
        end
        chk("out_en", 32'(out_en), 32'(exp));
    endtask
    task automatic do_reset();
        arst_n <= 1'b0;
        ticks(5);
        arst_n <= 1'b1;
        ticks(1);
    endtask

    task automatic t_powerup();
        rd(REG_CONFIG);
        chk("config", rdat, 32'(CFG_WSEL_RESET));
        rd(REG_IRQ_MASK);
        chk("irq_mask", rdat, 32'(IRQ_MASK_RESET));
        wr(8'hF0, 32'hFFFFFFFF);
        rd(8'hF0);
        chk("unmapped", rdat, 32'h0);
        wr(REG_OUTPUT_CTRL, 32'h1F);
        ticks(5);
        wait_out(5'h00, 20);
        sense.pump_ok <= 1'b1;
        wait_out(5'h1F, 10);
        $display("t_powerup done");
    endtask
    task automatic t_warning();
        sense.warn_high[0] <= 1'b1;
        ticks(3);
        wait_out(5'h1F, 3);
        rd(REG_QUICK_STATUS);
        chk("qs warn", 32'(rdat[4:0]), 32'h01);
        rd(cs(0));
        rd(cs(0));
        chk("warn hot", 32'(rdat[CS_WARN_BIT]), 32'h1);
        sense.warn_high[0] <= 1'b0;
        ticks(2);
        rd(cs(0));
        chk("warn latched", 32'(rdat[CS_WARN_BIT]), 32'h1);
        rd(cs(0));
        chk("warn cleared", 32'(rdat[CS_WARN_BIT]), 32'h0);
        wr(REG_CONFIG, 32'h1);
        sense.warn_low[1] <= 1'b1;
        sense.warn_high[2] <= 1'b1;
        ticks(3);
        rd(cs(1));
        chk("low thresh", 32'(rdat[CS_WARN_BIT]), 32'h1);
        rd(cs(2));
        chk("high ignored", 32'(rdat[CS_WARN_BIT]), 32'h0);
        sense.warn_low[1] <= 1'b0;
        sense.warn_high[2] <= 1'b0;
        ticks(2);
        wr(REG_CONFIG, 32'h0);
        $display("t_warning done");
    endtask
    task automatic t_shutdown();
        // Two glitches one cycle short of the filter, a one-cycle gap between
        repeat (2) begin
            sense.shutdown[3] <= 1'b1;
            ticks(OTS_N - 1);
            sense.shutdown[3] <= 1'b0;
            ticks(1);
        end
        wait_out(5'h1F, 1);
        rd(cs(3));
        chk("sd glitch", 32'(rdat[CS_SD_BIT]), 32'h0);
        sense.shutdown[3] <= 1'b1;
        wait_out(5'h17, OTS_N + 5);
        rd(REG_QUICK_STATUS);
        chk("qs sd", 32'(rdat[QS_SD_LSB+3]), 32'h1);
        wr(REG_CH_CTRL_BASE + 8'h0C, 32'h1);
        ticks(4);
        chk("on while hot", 32'(out_en), 32'h17);
        rd(cs(3));
        chk("sd hot read", 32'(rdat[CS_SD_BIT]), 32'h1);
        sense.shutdown[3] <= 1'b0;
        ticks(10);
        chk("no self restart", 32'(out_en), 32'h17);
        rd(cs(3));
        chk("sd latched", 32'(rdat[CS_SD_BIT]), 32'h1);
        rd(cs(3));
        chk("sd cleared", 32'(rdat[CS_SD_BIT]), 32'h0);
        wr(REG_CH_CTRL_BASE + 8'h0C, 32'h1);
        wait_out(5'h1F, 5);
        $display("t_shutdown done");
    endtask
    task automatic t_supply();
        sense.supply_low <= 1'b1;
        wait_out(5'h00, SUP_N + 6);
        rd(REG_DEVICE_STATUS);
        chk("ds low", 32'(rdat[2:0]), 32'h5);
        rd(cs(4));
        chk("cs summary", 32'(rdat[CS_DSF_BIT]), 32'h1);
        sense.supply_low <= 1'b0;
        ticks(10);
        chk("uv stays off", 32'(out_en), 32'h0);
        rd(REG_DEVICE_STATUS);
        rd(REG_DEVICE_STATUS);
        chk("low cleared", 32'(rdat[DS_LOW_BIT]), 32'h0);
        wr(REG_OUTPUT_CTRL, 32'h1F);
        wait_out(5'h1F, 5);
        sense.supply_high <= 1'b1;
        ticks(2);
        sense.supply_high <= 1'b0;
        rd(REG_DEVICE_STATUS);
        chk("ds high", 32'(rdat[2:0]), 32'h6);
        rd(REG_DEVICE_STATUS);
        chk("high cleared", 32'(rdat[2:0]), 32'h0);
        wait_out(5'h1F, 1);
        $display("t_supply done");
    endtask
    task automatic t_pump();
        sense.pump_ok <= 1'b0;
        wait_out(5'h00, 5);
        ticks(8);
        rd(REG_QUICK_STATUS);
        chk("qs pump", 32'(rdat[11:10]), 32'h3);
        wr(REG_CH_CTRL_BASE, 32'h1);
        sense.pump_ok <= 1'b1;
        wait_out(5'h1F, 5);
        rd(REG_QUICK_STATUS);
        rd(REG_QUICK_STATUS);
        chk("pump cleared", 32'(rdat[11:10]), 32'h0);
        $display("t_pump done");
    endtask
    task automatic t_fail();
        fail_mode <= 1'b1;
        sense.supply_low <= 1'b1;
        wait_out(5'h00, SUP_N + 6);
        sense.supply_low <= 1'b0;
        ticks(20);
        chk("no early restart", 32'(out_en), 32'h0);
        wait_out(5'h1F, AUTO_N + 10);
        sense.shutdown[4] <= 1'b1;
        wait_out(5'h0F, OTS_N + 5);
        sense.shutdown[4] <= 1'b0;
        ticks(2 * AUTO_N + 5);
        chk("fail no restart", 32'(out_en), 32'h0F);
        fail_mode <= 1'b0;
        wait_out(5'h1F, 10);
        $display("t_fail done");
    endtask
    task automatic t_irq();
        do_reset();
        wr(REG_IRQ_MASK, 32'(1 << EV_HIGH_SUPPLY));
        wr(REG_IRQ_STATUS, 32'h1F);
        sense.warn_high[1] <= 1'b1;
        ticks(3);
        chk("irq masked", 32'(irq), 32'h0);
        sense.supply_high <= 1'b1;
        ticks(1);
        sense.supply_high <= 1'b0;
        ticks(3);
        chk("irq raised", 32'(irq), 32'h1);
        rd(REG_IRQ_STATUS);
        chk("irq status", 32'(rdat[4:0]), 32'h09);
        wr(REG_IRQ_STATUS, 32'(1 << EV_HIGH_SUPPLY));
        ticks(2);
        chk("irq cleared", 32'(irq), 32'h0);
        $display("t_irq done");
    endtask

    initial begin
        arst_n = 1'b0;
        sense = '0;
        fail_mode = 1'b0;
        cyc_cnt = 0;
        err_total = 0;
        num_checks = 0;
        do_reset();
        t_powerup();
        t_warning();
        t_shutdown();
        t_supply();
        t_pump();
        t_fail();
        t_irq();
        give_verdict();
    end
endmodule

bind stfs_supervisor stfs_supervisor_sva #(.OTS_CYCLES(OTS_CYCLES), .SUPPLY_CYCLES(SUPPLY_CYCLES),
    .PUMP_CYCLES(PUMP_CYCLES), .AUTORESTART_CYCLES(AUTORESTART_CYCLES)) sva (.clk(clk), .arst_n(arst_n),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .sense(sense),
    .out_en(out_en), .inrush_overcurrent_window(inrush_overcurrent_window));
